// ===== pkg/uart_irq_consts.vh
// register offsets, field positions, reset values and timing counts
// assumes an apb slave with one aligned 32-bit word per register
`ifndef UART_IRQ_CONSTS_VH
`define UART_IRQ_CONSTS_VH
`define OFS_RX_HOLD 8'h00
`define OFS_TX_HOLD 8'h04
`define OFS_MASK 8'h08
`define OFS_SOURCE 8'h0c
`define OFS_QCTRL 8'h10
`define OFS_LINE 8'h14
`define OFS_HSIN 8'h18
`define OFS_EFC 8'h1c
`define OFS_CFG 8'h20
`define OFS_LEVEL 8'h24
`define MASK_RESET 8'h00
`define QCTRL_RESET 8'h00
`define EFC_RESET 8'h00
`define CFG_RESET 32'h0000_0101
`define EFC_ENH_BIT 4
`define EFC_AUTORTS_BIT 6
`define EFC_AUTOCTS_BIT 7
`define CFG_TXTRIG_LSB 8
`define CFG_RXTRIG_LSB 0
`define CFG_HALFDUP_BIT 16
`define CFG_BITTIME_LSB 24
`define QC_ENABLE 0
`define QC_RXRST 1
`define QC_TXRST 2
`define CODE_LINE 6'h06
`define CODE_TIMEOUT 6'h0c
`define CODE_RECEIVE_READY_EVENT 6'h04
`define CODE_TRANSMIT_READY_EVENT 6'h02
`define CODE_MODEM 6'h00
`define CODE_STOPCH 6'h10
`define CODE_HSHAKE 6'h20
`define CODE_NONE 6'h01
`define FIFO_DEPTH 128
`define CHAR_BITS 10
`define TIMEOUT_CHARS 4
`define TIMEOUT_EXTRA_BITS 12
`define TIMEOUT_BITS (`TIMEOUT_CHARS * `CHAR_BITS + `TIMEOUT_EXTRA_BITS)
`endif

// ===== core/uart_irq_ctrl.v
// interrupt enable, prioritised source code and queue control of a uart
// assumes an apb master on the sys clock; the receive/transmit shifters
// report events on single-cycle strobes synchronous to SYS_CLK
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "uart_irq_consts.vh"

// How it works
// - rx trigger reached raises receive interrupt
// - data ready set on push, cleared empty
// - line flags update even with enables zero
// - line flags: ready, overrun, errors, empties
// - mask bit0 gates receive ready
// - mask bit1 gates transmit ready, immediate
// - tx ready cleared by source read, write
// - half duplex: tx ready on shifter empty
// - mask bit2 gates line error interrupt
// - line read clears interrupt and overrun, keeps error flags
// - mask bit3 gates modem interrupt
// - timeout four chars plus twelve bits
// - mask bits 4-7 need enhanced enable
// - cts/rts rising edge raises handshake interrupt
// - stop/special character interrupt and clears
// - shown source held while pending, then highest pending shown
// - seven priority codes in bits 5:0
// - bit0 high when nothing pending
// - bits 7:6 show queue enable
// - queue writes need enable bit set
// - rx queue reset self-clears
// - tx queue reset self-clears
module uart_irq_ctrl
(
	input wire SYS_CLK,
	input wire RST_N,
	input wire CLK_EN,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire RX_PUSH,
	input wire [7:0] RX_CHAR,
	input wire [2:0] RX_ERR,
	input wire TX_SHIFT_POP,
	input wire TX_SHIFT_EMPTY,
	input wire [3:0] MODEM_DELTA,
	input wire STOP_CHAR_SEEN,
	input wire RESUME_CHAR_SEEN,
	input wire SPECIAL_CHAR_SEEN,
	input wire CTS_RISE,
	input wire RTS_RISE,
	output reg IRQ,
	output reg [7:0] TX_CHAR,
	output reg TX_VALID,
	output reg SLEEP_EN
);

////////////////////////////////////////////////////////////////////////
// state
reg [7:0] interrupt_mask;
reg [7:0] enhanced_function_control;
reg [31:0] cfg;
reg fifo_on;
reg [7:0] rx_data [0:`FIFO_DEPTH-1];
reg [2:0] rx_tag [0:`FIFO_DEPTH-1];
reg [6:0] rx_rd;
reg [6:0] rx_wr;
reg [7:0] rx_cnt;
reg [7:0] tx_data [0:`FIFO_DEPTH-1];
reg [6:0] tx_rd;
reg [6:0] tx_wr;
reg [7:0] tx_cnt;
reg overrun;
reg [7:0] err_cnt;
reg line_pend;
reg tx_pend;
reg modem_pend;
reg stop_pend;
reg special_pend;
reg hs_pend;
reg [3:0] modem_flags;
reg [15:0] bit_div;
reg [5:0] idle_bits;
reg timeout_pend;
reg [5:0] src_code;
reg tx_below_last;

////////////////////////////////////////////////////////////////////////
// apb decode
wire acc = PSEL & PENABLE & CLK_EN;
wire wr = acc & PWRITE;
wire rd = acc & ~PWRITE;
wire rd_rx = rd & (PADDR == `OFS_RX_HOLD);
wire wr_tx = wr & (PADDR == `OFS_TX_HOLD);
wire rd_src = rd & (PADDR == `OFS_SOURCE);
wire rd_line = rd & (PADDR == `OFS_LINE);
wire rd_hs = rd & (PADDR == `OFS_HSIN);
wire wr_q = wr & (PADDR == `OFS_QCTRL);
wire q_ok = wr_q & PWDATA[`QC_ENABLE];
wire rx_flush = q_ok & PWDATA[`QC_RXRST];
wire tx_flush = q_ok & PWDATA[`QC_TXRST];
wire mapped = (PADDR <= `OFS_LEVEL) && (PADDR[1:0] == 2'b00);

// queue capacity, trigger levels and pops
wire [7:0] cap = fifo_on ? 8'h80 : 8'h01;
wire [7:0] rx_trig = fifo_on ? cfg[`CFG_RXTRIG_LSB+:8] : 8'h01;
wire [7:0] tx_trig = fifo_on ? cfg[`CFG_TXTRIG_LSB+:8] : 8'h01;
wire rx_pop = rd_rx && (rx_cnt != 8'h00);
wire rx_in = RX_PUSH && (rx_cnt != cap) && !rx_flush;
wire tx_pop = TX_SHIFT_POP && (tx_cnt != 8'h00) && !tx_flush;
wire tx_in = wr_tx && (tx_cnt != cap);
wire [2:0] head_tag = rx_tag[rx_rd];
wire head_err = (rx_cnt != 8'h00) && (head_tag != 3'b000);

// line flags: bits 2-4 are the head byte's error tag
wire [7:0] line_flags = {(err_cnt != 8'h00),
	(tx_cnt == 8'h00) && TX_SHIFT_EMPTY, (tx_cnt == 8'h00),
	(head_err ? head_tag : 3'b000), overrun, (rx_cnt != 8'h00)};

// raw level conditions
wire rx_level = (rx_cnt >= rx_trig) && (rx_cnt != 8'h00);
wire tx_low = cfg[`CFG_HALFDUP_BIT] ? ((tx_cnt == 8'h00) && TX_SHIFT_EMPTY)
	: (tx_cnt < tx_trig);

////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		interrupt_mask <= `MASK_RESET;
		enhanced_function_control <= `EFC_RESET;
		cfg <= `CFG_RESET;
		fifo_on <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (wr && PADDR == `OFS_MASK)
		begin
			interrupt_mask[3:0] <= PWDATA[3:0];
			if (enhanced_function_control[`EFC_ENH_BIT])
				interrupt_mask[7:4] <= PWDATA[7:4];
		end
		if (wr && PADDR == `OFS_EFC)
			enhanced_function_control <= PWDATA[7:0];
		if (wr && PADDR == `OFS_CFG)
			cfg <= PWDATA;
		if (wr_q)
			fifo_on <= PWDATA[`QC_ENABLE];
	end
end

////////////////////////////////////////////////////////////////////////
// receive queue with per-byte error tags
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		rx_rd <= 7'h00;
		rx_wr <= 7'h00;
		rx_cnt <= 8'h00;
		err_cnt <= 8'h00;
		overrun <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (rx_flush)
		begin
			rx_rd <= 7'h00;
			rx_wr <= 7'h00;
			rx_cnt <= 8'h00;
			err_cnt <= 8'h00;
		end
		else
		begin
			if (rx_in)
			begin
				rx_data[rx_wr] <= RX_CHAR;
				rx_tag[rx_wr] <= RX_ERR;
				rx_wr <= rx_wr + 7'h01;
			end
			if (rx_pop)
				rx_rd <= rx_rd + 7'h01;
			rx_cnt <= rx_cnt + {7'h00, rx_in} - {7'h00, rx_pop};
			err_cnt <= err_cnt + {7'h00, rx_in && RX_ERR != 3'b000}
				- {7'h00, rx_pop && head_err};
		end
		// overrun set wins over the read that clears it
		if (RX_PUSH && rx_cnt == cap)
			overrun <= 1'b1;
		else if (rd_line)
			overrun <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// transmit queue
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		tx_rd <= 7'h00;
		tx_wr <= 7'h00;
		tx_cnt <= 8'h00;
		TX_CHAR <= 8'h00;
		TX_VALID <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (tx_flush)
		begin
			tx_rd <= 7'h00;
			tx_wr <= 7'h00;
			tx_cnt <= 8'h00;
		end
		else
		begin
			if (tx_in)
			begin
				tx_data[tx_wr] <= PWDATA[7:0];
				tx_wr <= tx_wr + 7'h01;
			end
			if (tx_pop)
				tx_rd <= tx_rd + 7'h01;
			tx_cnt <= tx_cnt + {7'h00, tx_in} - {7'h00, tx_pop};
		end
		TX_CHAR <= tx_data[tx_rd];
		TX_VALID <= (tx_cnt != 8'h00) && !tx_flush && !tx_pop;
	end
end

////////////////////////////////////////////////////////////////////////
// sticky event sources; every set wins over its clear
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		line_pend <= 1'b0;
		tx_pend <= 1'b0;
		modem_pend <= 1'b0;
		stop_pend <= 1'b0;
		special_pend <= 1'b0;
		hs_pend <= 1'b0;
		modem_flags <= 4'h0;
		tx_below_last <= 1'b1;
	end
	else if (CLK_EN)
	begin
		tx_below_last <= tx_low;
		// overrun now, data errors when the bad byte is read
		if ((RX_PUSH && rx_cnt == cap) || (rx_pop && head_err))
			line_pend <= 1'b1;
		else if (rd_line)
			line_pend <= 1'b0;
		if ((tx_low && !tx_below_last) ||
			(wr && PADDR == `OFS_MASK && PWDATA[1] &&
			!interrupt_mask[1] && tx_low))
			tx_pend <= 1'b1;
		else if (rd_src || wr_tx)
			tx_pend <= 1'b0;
		if (MODEM_DELTA != 4'h0)
			modem_flags <= modem_flags | MODEM_DELTA;
		else if (rd_hs)
			modem_flags <= 4'h0;
		if (MODEM_DELTA != 4'h0)
			modem_pend <= 1'b1;
		else if (rd_hs)
			modem_pend <= 1'b0;
		if (STOP_CHAR_SEEN)
			stop_pend <= 1'b1;
		else if (rd_src || RESUME_CHAR_SEEN)
			stop_pend <= 1'b0;
		if (SPECIAL_CHAR_SEEN)
			special_pend <= 1'b1;
		else if (rd_src || RX_PUSH)
			special_pend <= 1'b0;
		if ((CTS_RISE && enhanced_function_control[`EFC_AUTOCTS_BIT]) ||
			(RTS_RISE && enhanced_function_control[`EFC_AUTORTS_BIT]))
			hs_pend <= 1'b1;
		else if (rd_hs)
			hs_pend <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// receive timeout: idle bit times with data waiting
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		bit_div <= 16'h0000;
		idle_bits <= 6'h00;
		timeout_pend <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (RX_PUSH || rx_pop || rx_cnt == 8'h00)
		begin
			bit_div <= 16'h0000;
			idle_bits <= 6'h00;
		end
		else if (bit_div >= {cfg[31:`CFG_BITTIME_LSB], 8'h00})
		begin
			bit_div <= 16'h0000;
			if (idle_bits != 6'h3f)
				idle_bits <= idle_bits + 6'h01;
		end
		else
			bit_div <= bit_div + 16'h0001;
		if (idle_bits == `TIMEOUT_BITS && rx_cnt != 8'h00)
			timeout_pend <= 1'b1;
		else if (rx_cnt == 8'h00)
			timeout_pend <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// priority encoder, held while a source is being serviced
wire [6:0] act = {hs_pend & interrupt_mask[6] | hs_pend & interrupt_mask[7],
	(stop_pend | special_pend) & interrupt_mask[5],
	modem_pend & interrupt_mask[3],
	tx_pend & interrupt_mask[1],
	rx_level & interrupt_mask[0],
	timeout_pend & interrupt_mask[0],
	line_pend & interrupt_mask[2]};
reg [5:0] next_code;
always @*
begin
	next_code = `CODE_NONE;
	if (act[0])
		next_code = `CODE_LINE;
	else if (act[1])
		next_code = `CODE_TIMEOUT;
	else if (act[2])
		next_code = `CODE_RECEIVE_READY_EVENT;
	else if (act[3])
		next_code = `CODE_TRANSMIT_READY_EVENT;
	else if (act[4])
		next_code = `CODE_MODEM;
	else if (act[5])
		next_code = `CODE_STOPCH;
	else if (act[6])
		next_code = `CODE_HSHAKE;
end

// the shown source stays until it is no longer pending
wire cur_live = (src_code == `CODE_LINE) ? act[0] :
	(src_code == `CODE_TIMEOUT) ? act[1] :
	(src_code == `CODE_RECEIVE_READY_EVENT) ? act[2] :
	(src_code == `CODE_TRANSMIT_READY_EVENT) ? act[3] :
	(src_code == `CODE_MODEM) ? act[4] :
	(src_code == `CODE_STOPCH) ? act[5] :
	(src_code == `CODE_HSHAKE) ? act[6] : 1'b0;

always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		src_code <= `CODE_NONE;
		IRQ <= 1'b0;
		SLEEP_EN <= 1'b0;
	end
	else if (CLK_EN)
	begin
		if (!cur_live)
			src_code <= next_code;
		IRQ <= (act != 7'h00);
		SLEEP_EN <= interrupt_mask[4];
	end
end

////////////////////////////////////////////////////////////////////////
// apb read data and response
reg [31:0] next_rdata;
always @*
begin
	next_rdata = 32'h0000_0000;
	case (PADDR)
		`OFS_RX_HOLD: next_rdata = {24'h0, rx_data[rx_rd]};
		`OFS_MASK: next_rdata = {24'h0, interrupt_mask};
		`OFS_SOURCE: next_rdata = {24'h0, {2{fifo_on}}, src_code};
		`OFS_LINE: next_rdata = {24'h0, line_flags};
		`OFS_HSIN: next_rdata = {24'h0, 4'h0, modem_flags};
		`OFS_EFC: next_rdata = {24'h0, enhanced_function_control};
		`OFS_CFG: next_rdata = cfg;
		`OFS_LEVEL: next_rdata = {8'h0, tx_cnt, 8'h0, rx_cnt};
		default: next_rdata = 32'h0000_0000;
	endcase
end

always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		PRDATA <= 32'h0000_0000;
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
	end
	else if (CLK_EN)
	begin
		PREADY <= PSEL & ~PENABLE;
		PSLVERR <= PSEL & ~PENABLE & ~mapped;
		if (PSEL & ~PENABLE & ~PWRITE)
			PRDATA <= next_rdata;
	end
end

endmodule // uart_irq_ctrl
`default_nettype wire

// ===== sim/uart_irq_checker.sv
// checker: apb timing and interrupt raise of uart_irq_ctrl
// bound in tb_top, sees only the top ports
`timescale 1ns/1ns
`default_nettype none
module uart_irq_checker
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [3:0] MODEM_DELTA,
	input wire logic CTS_RISE,
	input wire logic IRQ,
	input wire logic SLEEP_EN
);
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (!RST_N);
logic [7:0] msk;
logic [7:0] efc;
////////////////////////////////////////////////////////////////////////
// shadow of mask and enhanced enable from apb writes
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		msk <= 8'h00;
		efc <= 8'h00;
	end
	else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h08)
		msk <= {efc[4] ? PWDATA[7:4] : msk[7:4], PWDATA[3:0]};
	else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h1c)
		efc <= PWDATA[7:0];
end
sequence s_setup;
	PSEL && !PENABLE;
endsequence
sequence s_access;
	PSEL && PENABLE;
endsequence
////////////////////////////////////////////////////////////////////////
// bus answer and interrupt timing
a_ready_access: assert property (s_setup ##1 s_access |-> PREADY)
	else $error("ready missing in access cycle");
a_ready_single: assert property (PREADY |=> !PREADY)
	else $error("ready held too long");
a_ready_phase: assert property (PREADY |-> s_access)
	else $error("ready outside access");
a_err_unmapped: assert property (PREADY && PADDR > 8'h24 |-> PSLVERR)
	else $error("unmapped access not refused");
a_mask_quiet: assert property ((msk == 8'h00) [*3] |-> !IRQ)
	else $error("irq with all sources masked");
a_modem_raise: assert property (MODEM_DELTA != 4'h0 && msk[3] |-> ##2 IRQ)
	else $error("modem event gave no irq");
a_cts_raise: assert property (CTS_RISE && efc[7] && msk[7] |-> ##2 IRQ)
	else $error("cts rise gave no irq");
a_sleep_copy: assert property ($stable(msk) |-> SLEEP_EN == msk[4])
	else $error("sleep enable differs from mask");
endmodule // uart_irq_checker
`default_nettype wire

// ===== sim/tx_shifter_model.sv
// model: transmit shifter taking bytes from the tx queue
// assumes tx_valid registered on the same clock
`timescale 1ns/1ns
`default_nettype none
module tx_shifter_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_valid,
	input wire logic stall,
	output logic pop,
	output logic empty
);
// one pop per byte with a gap after it; idle while stalled
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		pop <= 1'b0;
		empty <= 1'b1;
	end
	else
	begin
		pop <= tx_valid && !pop && !stall;
		empty <= !tx_valid && !pop;
	end
end
endmodule // tx_shifter_model
`default_nettype wire

// ===== sim/tb_top.sv
// bench: apb stimulus and read checks for uart_irq_ctrl
// assumes the checker and the tx shifter model beside it
`timescale 1ns/1ns
`default_nettype none
`include "uart_irq_consts.vh"
module tb_top;
logic SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, RX_PUSH, CTS_RISE, IRQ;
logic PREADY, PSLVERR, TX_VALID, SLEEP_EN, stall, pop, sempty;
logic [7:0] PADDR, RX_CHAR, TX_CHAR, r;
logic [31:0] PWDATA, PRDATA;
logic [2:0] RX_ERR;
logic [3:0] MODEM_DELTA;
logic [7:0] rq[$];
logic [7:0] tq[$];
int miscompares, checks_done, cyc, seed, i;
uart_irq_ctrl u_uart_irq_ctrl (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.CLK_EN(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .RX_PUSH(RX_PUSH), .RX_CHAR(RX_CHAR),
	.RX_ERR(RX_ERR), .TX_SHIFT_POP(pop), .TX_SHIFT_EMPTY(sempty),
	.MODEM_DELTA(MODEM_DELTA), .STOP_CHAR_SEEN(1'b0),
	.RESUME_CHAR_SEEN(1'b0), .SPECIAL_CHAR_SEEN(1'b0),
	.CTS_RISE(CTS_RISE), .RTS_RISE(1'b0), .IRQ(IRQ), .TX_CHAR(TX_CHAR),
	.TX_VALID(TX_VALID), .SLEEP_EN(SLEEP_EN));
tx_shifter_model u_tx_shifter_model (.clk(SYS_CLK), .rst_n(RST_N),
	.tx_valid(TX_VALID), .stall(stall), .pop(pop), .empty(sempty));
////////////////////////////////////////////////////////////////////////
task chk(input string n, input logic [7:0] s, input logic [7:0] e);
	checks_done++;
	if (s !== e)
	begin
		miscompares++;
		$display("MISMATCH %s expected %h seen %h", n, e, s);
	end
endtask
task complete_run;
	$display("checks %0d mismatches %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
// one apb transfer; a checked read notes its expected byte
task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
	input logic c);
	@(posedge SYS_CLK);
	if (c)
		rq.push_back(d[7:0]);
	PSEL <= 1'b1;
	PENABLE <= 1'b0;
	PWRITE <= w;
	PADDR <= a;
	PWDATA <= w ? d : 32'h0;
	@(posedge SYS_CLK);
	PENABLE <= 1'b1;
	do @(posedge SYS_CLK); while (PREADY !== 1'b1);
	PSEL <= 1'b0;
	PENABLE <= 1'b0;
endtask
// one-cycle event pulse, then time for the status to settle
task ev(input logic p, input logic [2:0] e, input logic [3:0] m,
	input logic t);
	@(posedge SYS_CLK);
	RX_PUSH <= p;
	RX_CHAR <= r;
	RX_ERR <= e;
	MODEM_DELTA <= m;
	CTS_RISE <= t;
	@(posedge SYS_CLK);
	RX_PUSH <= 1'b0;
	MODEM_DELTA <= 4'h0;
	CTS_RISE <= 1'b0;
	repeat (3) @(posedge SYS_CLK);
endtask
////////////////////////////////////////////////////////////////////////
// clock
initial
begin
	SYS_CLK = 1'b0;
	forever #4 SYS_CLK = ~SYS_CLK;
end
// watcher: timeout and comparison of reads and popped bytes
always @(posedge SYS_CLK)
begin
	cyc++;
	if (cyc == 20000)
	begin
		miscompares++;
		complete_run;
	end
	if (PSEL && PENABLE && PREADY && !PWRITE && rq.size() > 0)
		chk("prdata", PRDATA[7:0], rq.pop_front());
	// interrupt pin against the pending bit of each source read
	if (PSEL && PENABLE && PREADY && !PWRITE && PADDR == `OFS_SOURCE)
		chk("irq", {7'h00, IRQ}, {7'h00, ~PRDATA[0]});
	if (pop && tq.size() > 0)
		chk("tx_char", TX_CHAR, tq.pop_front());
end
// main sequence
initial
begin
	{RST_N, PSEL, PENABLE, PWRITE, RX_PUSH, CTS_RISE, stall} = 7'h0;
	PADDR = 8'h00;
	PWDATA = 32'h0;
	RX_CHAR = 8'h00;
	RX_ERR = 3'h0;
	MODEM_DELTA = 4'h0;
	seed = 27;
	repeat (5) @(posedge SYS_CLK);
	RST_N <= 1'b1;
	bus(0, `OFS_SOURCE, 8'h01, 1);
	bus(0, `OFS_MASK, 8'h00, 1);
	bus(1, `OFS_MASK, 32'hf0, 0);
	bus(0, `OFS_MASK, 8'h00, 1);
	bus(1, `OFS_QCTRL, 32'h01, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	bus(1, `OFS_MASK, 32'h02, 0);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc2, 1);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	stall <= 1'b1;
	r = $random(seed);
	tq.push_back(r);
	bus(1, `OFS_TX_HOLD, {24'h0, r}, 0);
	stall <= 1'b0;
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc2, 1);
	bus(1, `OFS_MASK, 32'h01, 0);
	r = $random(seed);
	ev(1, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc4, 1);
	bus(0, `OFS_LINE, 8'h61, 1);
	bus(0, `OFS_RX_HOLD, r, 1);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_LINE, 8'h60, 1);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	bus(1, `OFS_CFG, 32'h102, 0);
	r = $random(seed);
	ev(1, 3'h0, 4'h0, 0);
	repeat (60) @(posedge SYS_CLK);
	bus(0, `OFS_SOURCE, 8'hcc, 1);
	bus(0, `OFS_RX_HOLD, r, 1);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	bus(1, `OFS_MASK, 32'h04, 0);
	ev(1, 3'b010, 4'h0, 0);
	bus(0, `OFS_RX_HOLD, r, 1);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc6, 1);
	bus(0, `OFS_LINE, 32'h0, 0);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	bus(1, `OFS_MASK, 32'h08, 0);
	ev(0, 3'h0, 4'h5, 0);
	bus(0, `OFS_SOURCE, 8'hc0, 1);
	bus(0, `OFS_HSIN, 8'h05, 1);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	ev(1, 3'h0, 4'h0, 0);
	ev(1, 3'h0, 4'h0, 0);
	bus(0, `OFS_LEVEL, 8'h02, 1);
	bus(1, `OFS_QCTRL, 32'h03, 0);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_LEVEL, 8'h00, 1);
	bus(1, `OFS_EFC, 32'h90, 0);
	bus(1, `OFS_MASK, 32'h90, 0);
	ev(0, 3'h0, 4'h0, 1);
	bus(0, `OFS_SOURCE, 8'he0, 1);
	bus(0, `OFS_HSIN, 32'h0, 0);
	ev(0, 3'h0, 4'h0, 0);
	bus(0, `OFS_SOURCE, 8'hc1, 1);
	// random masks read back with the enhanced bit set
	for (i = 0; i < 4; i++)
	begin
		r = $random(seed);
		bus(1, `OFS_MASK, {24'h0, r}, 0);
		bus(0, `OFS_MASK, r, 1);
	end
	bus(0, 8'h40, 8'h00, 1);
	complete_run;
end
endmodule // tb_top
bind uart_irq_ctrl uart_irq_checker u_uart_irq_checker (.SYS_CLK(SYS_CLK),
	.RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.MODEM_DELTA(MODEM_DELTA), .CTS_RISE(CTS_RISE), .IRQ(IRQ),
	.SLEEP_EN(SLEEP_EN));
`default_nettype wire
